// *** rtl/pci_config_header_regs.sv ***
// Upper PCI configuration header registers, strap mode and local window claim.
`timescale 1ns/1ps
module pci_config_header_regs
  import pci_cfg_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION = 8'h00, // Arbitrary value.
  parameter int CFG_ADDR_W = 12
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Mode strap and command register state.
  input wire logic local_mode_strap_i,
  input wire logic memory_space_enable_i,
  // Configuration access.
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic [CFG_ADDR_W-1:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_n_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ack_o,
  output logic cfg_refused_o,
  output logic [31:0] cfg_rdata_o,
  // Memory cycle decode.
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_claim_o,
  // Status.
  output logic [WIN_W-1:0] window_base_o,
  output logic local_mode_o
);
  if (CFG_ADDR_W < 9 || CFG_ADDR_W > 12) begin : g_check
    $error("CFG_ADDR_W must lie between 9 and 12");
  end

  logic strap_taken;
  local_mode_t mode;
  logic next_strap_taken;
  local_mode_t next_mode;
  logic [11:0] addr;
  logic take;
  logic bridge;
  logic [31:0] lane_mask;
  logic wr_ok;
  logic [7:0] int_line;
  logic [31:0] rd_word;
  logic win_hit;
  logic next_ack;
  logic next_refused;
  logic [31:0] next_rdata;
  logic next_claim;

  // The strap is caught once after reset release, so a pin that moves later cannot
  // flip the mode in the middle of traffic.
  always_comb begin
    next_strap_taken = 1'b1;
    next_mode = mode;
    if (!strap_taken) begin
      next_mode = local_mode_strap_i ? MODE_CONFIG : MODE_BRIDGE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_taken <= 1'b0;
      mode <= MODE_BRIDGE;
    end else begin
      strap_taken <= next_strap_taken;
      mode <= next_mode;
    end
  end

  assign addr = 12'(cfg_addr_i);
  assign bridge = strap_taken && (mode == MODE_BRIDGE);
  assign take = cfg_req_i && strap_taken;
  assign wr_ok = take && cfg_we_i && bridge;
  assign lane_mask = {{8{~cfg_be_n_i[3]}}, {8{~cfg_be_n_i[2]}},
                      {8{~cfg_be_n_i[1]}}, {8{~cfg_be_n_i[0]}}};

  // Only the upper twelve base bits take a write; the rest never see wr_i.
  masked_write_reg #(
    .WIDTH(WIN_W),
    .RESET(WIN_BASE_RST)
  ) u_base (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_ok && addr == OFF_WIN_BASE),
    .mask_i(lane_mask[31:WIN_LSB]),
    .data_i(cfg_wdata_i[31:WIN_LSB]),
    .q_o(window_base_o)
  );

  masked_write_reg #(
    .WIDTH(8),
    .RESET(INT_LINE_RST)
  ) u_int_line (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_ok && addr == OFF_INT_GRANT),
    .mask_i(lane_mask[7:0]),
    .data_i(cfg_wdata_i[7:0]),
    .q_o(int_line)
  );

  // Read-only fields are constants here, so writes to them have nothing to land in.
  always_comb begin
    case (addr)
      OFF_REV_CLASS: begin
        rd_word = {CLASS_BASE, CLASS_SUB, CLASS_IFACE, SILICON_REVISION};
      end
      OFF_LAT_HDR: begin
        rd_word = {SELF_TEST, HDR_TYPE, LAT_TIMER, CACHE_LINE};
      end
      OFF_WIN_BASE: begin
        rd_word = {window_base_o, BASE_SIZE_BITS, BASE_FLAGS};
      end
      OFF_INT_GRANT: begin
        rd_word = {MAX_LAT, MIN_GRANT, INT_PIN, int_line};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  window_decoder #(
    .WIDTH(WIN_W)
  ) u_decode (
    .base_i(window_base_o),
    .addr_hi_i(mem_addr_i[31:WIN_LSB]),
    .enable_i(memory_space_enable_i && bridge),
    .hit_o(win_hit)
  );

  // Every taken write in bridge mode completes, even to a read-only field; in configuration mode it is refused.
  always_comb begin
    next_ack = take && bridge;
    next_refused = take && !bridge;
    next_rdata = 32'h0000_0000;
    if (take && bridge && !cfg_we_i) begin
      next_rdata = rd_word;
    end
    next_claim = mem_req_i && win_hit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ack_o <= 1'b0;
      cfg_refused_o <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
      mem_claim_o <= 1'b0;
      local_mode_o <= 1'b0;
    end else begin
      cfg_ack_o <= next_ack;
      cfg_refused_o <= next_refused;
      cfg_rdata_o <= next_rdata;
      mem_claim_o <= next_claim;
      local_mode_o <= next_mode;
    end
  end

  // Helper state for the checks below: the address of the previous cycle and whether it was a taken bridge-mode read.
  logic [11:0] chk_addr;
  logic chk_rd;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_addr <= 12'h000;
      chk_rd <= 1'b0;
    end else begin
      chk_addr <= addr;
      chk_rd <= take && bridge && !cfg_we_i;
    end
  end

  property p_revision;
    @(posedge clk_i) disable iff (rst_i)
      chk_rd && chk_addr == OFF_REV_CLASS |-> cfg_rdata_o[7:0] == SILICON_REVISION;
  endproperty
  a_revision: assert property (p_revision) else $error("revision byte wrong");

  property p_class;
    @(posedge clk_i) disable iff (rst_i)
      chk_rd && chk_addr == OFF_REV_CLASS |-> cfg_rdata_o[31:8] == 24'h068000;
  endproperty
  a_class: assert property (p_class) else $error("class code wrong");

  property p_lat_hdr;
    @(posedge clk_i) disable iff (rst_i)
      chk_rd && chk_addr == OFF_LAT_HDR |-> cfg_rdata_o == 32'h0080_0000;
  endproperty
  a_lat_hdr: assert property (p_lat_hdr) else $error("header word wrong");

  property p_base_low;
    @(posedge clk_i) disable iff (rst_i)
      chk_rd && chk_addr == OFF_WIN_BASE |-> cfg_rdata_o[19:0] == 20'h00000;
  endproperty
  a_base_low: assert property (p_base_low) else $error("base low bits set");

  property p_base_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_ok && addr == OFF_WIN_BASE && cfg_be_n_i == 4'h0
        |=> window_base_o == $past(cfg_wdata_i[31:20]);
  endproperty
  a_base_write: assert property (p_base_write) else $error("base not stored");

  property p_int_line;
    @(posedge clk_i) disable iff (rst_i)
      wr_ok && addr == OFF_INT_GRANT && !cfg_be_n_i[0]
        |=> int_line == $past(cfg_wdata_i[7:0]);
  endproperty
  a_int_line: assert property (p_int_line) else $error("interrupt line lost");

  property p_int_read;
    @(posedge clk_i) disable iff (rst_i)
      chk_rd && chk_addr == OFF_INT_GRANT |-> cfg_rdata_o[7:0] == $past(int_line);
  endproperty
  a_int_read: assert property (p_int_read) else $error("interrupt line read wrong");

  property p_base_keep;
    @(posedge clk_i) disable iff (rst_i)
      wr_ok && addr == OFF_WIN_BASE && cfg_be_n_i[3]
        |=> $stable(window_base_o[11:4]);
  endproperty
  a_base_keep: assert property (p_base_keep) else $error("disabled base lane written");

  property p_int_fixed;
    @(posedge clk_i) disable iff (rst_i)
      chk_rd && chk_addr == OFF_INT_GRANT |-> cfg_rdata_o[31:8] == 24'h000001;
  endproperty
  a_int_fixed: assert property (p_int_fixed) else $error("pin or grant wrong");

  property p_mode_hold;
    @(posedge clk_i) disable iff (rst_i)
      strap_taken |=> $stable(local_mode_o);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

  property p_mode_capture;
    @(posedge clk_i) disable iff (rst_i)
      !strap_taken |=> local_mode_o == $past(local_mode_strap_i);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("strap not captured");

  property p_refuse;
    @(posedge clk_i) disable iff (rst_i)
      take && mode == MODE_CONFIG |=> cfg_refused_o && !cfg_ack_o && cfg_rdata_o == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("config mode access taken");

  property p_mse_off;
    @(posedge clk_i) disable iff (rst_i)
      !memory_space_enable_i |=> !mem_claim_o;
  endproperty
  a_mse_off: assert property (p_mse_off) else $error("claim while disabled");

  property p_claim;
    @(posedge clk_i) disable iff (rst_i)
      mem_req_i && bridge && memory_space_enable_i && mem_addr_i[31:20] == window_base_o
        |=> mem_claim_o;
  endproperty
  a_claim: assert property (p_claim) else $error("window hit not claimed");

  property p_claim_match;
    @(posedge clk_i) disable iff (rst_i)
      mem_claim_o |-> $past(mem_addr_i[31:20]) == $past(window_base_o);
  endproperty
  a_claim_match: assert property (p_claim_match) else $error("claim without match");

  property p_ro_write;
    @(posedge clk_i) disable iff (rst_i)
      take && bridge && cfg_we_i && addr == OFF_LAT_HDR
        |=> cfg_ack_o && $stable(window_base_o) && $stable(int_line);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write mishandled");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      take && bridge |=> cfg_ack_o && !cfg_refused_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bridge access not completed");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (rst_i)
      !chk_rd |-> cfg_rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");
endmodule

// *** include/pci_cfg_pkg.sv ***
// Constants for the upper PCI configuration header registers and window decode.
package pci_cfg_pkg;
  // Register offsets within configuration space.
  localparam logic [11:0] OFF_REV_CLASS = 12'h108;
  localparam logic [11:0] OFF_LAT_HDR = 12'h10c;
  localparam logic [11:0] OFF_WIN_BASE = 12'h110;
  localparam logic [11:0] OFF_INT_GRANT = 12'h13c;
  // Fixed byte values.
  localparam logic [7:0] CLASS_IFACE = 8'h00;
  localparam logic [7:0] CLASS_SUB = 8'h80;
  localparam logic [7:0] CLASS_BASE = 8'h06;
  localparam logic [7:0] CACHE_LINE = 8'h00;
  localparam logic [7:0] LAT_TIMER = 8'h00;
  localparam logic [7:0] HDR_TYPE = 8'h80;
  localparam logic [7:0] SELF_TEST = 8'h00;
  localparam logic [7:0] INT_PIN = 8'h01;
  localparam logic [7:0] MIN_GRANT = 8'h00;
  localparam logic [7:0] MAX_LAT = 8'h00;
  // Base address register layout.
  localparam int SPACE_INDICATOR_BIT = 0;
  localparam int PLACEMENT_TYPE_LOW_BIT = 1;
  localparam int PLACEMENT_TYPE_HIGH_BIT = 2;
  localparam int PREFETCHABLE_BIT = 3;
  localparam logic [3:0] BASE_FLAGS = 4'h0;
  localparam logic [15:0] BASE_SIZE_BITS = 16'h0000;
  localparam int WIN_LSB = 20;
  localparam int WIN_W = 12;
  // Reset values of the writable fields.
  localparam logic [11:0] WIN_BASE_RST = 12'h000;
  localparam logic [7:0] INT_LINE_RST = 8'h00;
  // Local bus operating mode taken from the strap.
  typedef enum logic {
    MODE_BRIDGE = 1'b0,
    MODE_CONFIG = 1'b1
  } local_mode_t;
endpackage

// *** rtl/masked_write_reg.sv ***
// Writable register field with a per-bit write mask.
`timescale 1ns/1ps
module masked_write_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port.
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] mask_i,
  input wire logic [WIDTH-1:0] data_i,
  // Stored value.
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_q = q_o;
    if (wr_i) begin
      next_q = (q_o & ~mask_i) | (data_i & mask_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= RESET;
    end else begin
      q_o <= next_q;
    end
  end
endmodule

// *** rtl/window_decoder.sv ***
// Compares the upper address bits of a memory cycle with the programmed window base.
`timescale 1ns/1ps
module window_decoder #(
  parameter int WIDTH = 12
) (
  // Programmed base and incoming address.
  input wire logic [WIDTH-1:0] base_i,
  input wire logic [WIDTH-1:0] addr_hi_i,
  input wire logic enable_i,
  // Combinational match.
  output logic hit_o
);
  always_comb begin
    hit_o = enable_i && (addr_hi_i == base_i);
  end
endmodule

// *** testbench/host_model.sv ***
// Behavioural PCI host that issues configuration and memory cycles.
`timescale 1ns/1ps
module host_model (
  // Clock.
  input wire logic clk_i,
  // Configuration cycle.
  output logic cfg_req_o,
  output logic cfg_we_o,
  output logic [11:0] cfg_addr_o,
  output logic [3:0] cfg_be_n_o,
  output logic [31:0] cfg_wdata_o,
  input wire logic cfg_ack_i,
  input wire logic cfg_refused_i,
  input wire logic [31:0] cfg_rdata_i,
  // Memory cycle.
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_claim_i
);
  initial begin
    cfg_req_o = 1'b0;
    cfg_we_o = 1'b0;
    cfg_addr_o = 12'h000;
    cfg_be_n_o = 4'hf;
    cfg_wdata_o = 32'h0;
    mem_req_o = 1'b0;
    mem_addr_o = 32'h0;
  end
  // Released address and data lines show the inverse value so stale data cannot pass for a live request.
  // Each task starts just after a rising edge and returns just after the edge at which
  // the answer is sampled, so calls chain without racing the design's outputs.
  task automatic cfg(input logic we, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd, output logic ack, output logic rf,
                     output logic [31:0] rd);
    cfg_req_o <= 1'b1;
    cfg_we_o <= we;
    cfg_addr_o <= a;
    cfg_be_n_o <= be;
    cfg_wdata_o <= wd;
    @(posedge clk_i);
    cfg_req_o <= 1'b0;
    cfg_addr_o <= ~a;
    cfg_wdata_o <= ~wd;
    @(posedge clk_i);
    ack = cfg_ack_i;
    rf = cfg_refused_i;
    rd = cfg_rdata_i;
  endtask
  task automatic mem(input logic [31:0] a, output logic claim);
    mem_req_o <= 1'b1;
    mem_addr_o <= a;
    @(posedge clk_i);
    mem_req_o <= 1'b0;
    mem_addr_o <= ~a;
    @(posedge clk_i);
    claim = mem_claim_i;
  endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the upper configuration header registers.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary value.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap = 1'b0;
  logic mse = 1'b0;
  logic cfg_req, cfg_we, cfg_ack, cfg_refused, mem_req, mem_claim, local_mode;
  logic [11:0] cfg_addr, window_base;
  logic [3:0] cfg_be_n;
  logic [31:0] cfg_wdata, cfg_rdata, mem_addr;
  int n_mismatch = 0;
  int n_checks = 0;
  int win, iline, mode;
  logic [11:0] offs[$] = '{12'h108, 12'h10c, 12'h110, 12'h13c, 12'h100};
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  pci_config_header_regs #(.SILICON_REVISION(REV), .CFG_ADDR_W(12)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .local_mode_strap_i(strap), .memory_space_enable_i(mse),
    .cfg_req_i(cfg_req), .cfg_we_i(cfg_we), .cfg_addr_i(cfg_addr), .cfg_be_n_i(cfg_be_n),
    .cfg_wdata_i(cfg_wdata), .cfg_ack_o(cfg_ack), .cfg_refused_o(cfg_refused),
    .cfg_rdata_o(cfg_rdata), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
    .mem_claim_o(mem_claim), .window_base_o(window_base), .local_mode_o(local_mode));
  host_model host (
    .clk_i(clk_i), .cfg_req_o(cfg_req), .cfg_we_o(cfg_we), .cfg_addr_o(cfg_addr),
    .cfg_be_n_o(cfg_be_n), .cfg_wdata_o(cfg_wdata), .cfg_ack_i(cfg_ack),
    .cfg_refused_i(cfg_refused), .cfg_rdata_i(cfg_rdata), .mem_req_o(mem_req),
    .mem_addr_o(mem_addr), .mem_claim_i(mem_claim));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] model_rd(input logic [11:0] a);
    case (a)
      12'h108: return {8'h06, 8'h80, 8'h00, REV};
      12'h10c: return 32'h0080_0000;
      12'h110: return {win[11:0], 20'h0};
      12'h13c: return {16'h0, 8'h01, iline[7:0]};
      default: return 32'h0;
    endcase
  endfunction
  task automatic do_reset(input logic s);
    rst_i <= 1'b1;
    strap <= s;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    win = 0;
    iline = 0;
    mode = s;
    // Edge one after release captures the strap; requests are taken from edge two.
    repeat (2) @(posedge clk_i);
    chk("local_mode_o", {31'h0, s}, {31'h0, local_mode});
    chk("window_base_o", 32'h0, {20'h0, window_base});
  endtask
  // Read data must stay zero on writes and on refused accesses.
  task automatic acc(input logic we, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    logic ack, rf;
    logic [31:0] rd;
    host.cfg(we, a, be, wd, ack, rf, rd);
    chk("cfg_ack_o", {31'h0, mode == 0}, {31'h0, ack});
    chk("cfg_refused_o", {31'h0, mode == 1}, {31'h0, rf});
    chk("cfg_rdata_o", (mode || we) ? 32'h0 : model_rd(a), rd);
    if (we && mode == 0 && a == 12'h110) begin
      if (!be[2]) win[3:0] = wd[23:20];
      if (!be[3]) win[11:4] = wd[31:24];
    end
    if (we && mode == 0 && a == 12'h13c && !be[0]) iline[7:0] = wd[7:0];
  endtask
  task automatic mem_run(input int n);
    logic claim;
    logic [31:0] a;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      mse <= k[0];
      a = {k[1] ? win[11:0] : 12'($urandom), 20'($urandom)};
      host.mem(a, claim);
      chk("mem_claim_o", {31'h0, k[0] && mode == 0 && a[31:20] == win[11:0]},
          {31'h0, claim});
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim;
  end
  initial begin
    void'($urandom(75940));
    do_reset(1'b0);
    foreach (offs[i]) acc(1'b0, offs[i], 4'hf, 32'h0);
    $display("test reset reads done");
    for (int k = 0; k < 30; k++) begin
      acc(1'b1, offs[k % 5], k < 5 ? 4'h0 : 4'($urandom),
          k < 5 ? 32'hffff_ffff : $urandom);
      acc(1'b0, offs[k % 5], 4'hf, 32'h0);
      acc(1'b0, 12'h110, 4'hf, 32'h0);
    end
    chk("window_base_o", {20'h0, win[11:0]}, {20'h0, window_base});
    $display("test writes done");
    mem_run(24);
    $display("test window decode done");
    do_reset(1'b1);
    acc(1'b1, 12'h110, 4'h0, 32'hfff0_0000);
    acc(1'b0, 12'h108, 4'hf, 32'h0);
    mem_run(4);
    chk("window_base_o", 32'h0, {20'h0, window_base});
    $display("test configuration mode done");
    end_sim;
  end
endmodule
